// [hw/cmpx_ctrl_top.sv]
// comparator input select and edge interrupt control with an axi4-lite register slave
//
// Notes on behaviour
// [R1] falling enable set: falling result sets flag
// [R2] falling enable clear: falling result ignored
// [R3] positive select: pin, dac, fixed ref, ground
// [R4] negative select field sits in bits 2-0
// [R5] negative code 100 picks fixed ref; others reserved (the code also routes 000 to pin zero and 001 to pin one)
// [R6] rising enable gates flag on rising result
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cmpx_ctrl_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // comparator side
    input wire logic cmp_result_bit,
    output logic [1:0] pos_input_sel,
    output logic [2:0] neg_input_sel,
    output logic [3:0] pos_route,
    output logic [2:0] neg_route,
    output logic neg_sel_reserved,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl_ff, nxt_ctrl;      // comparator_input_select_ctrl
    logic [0:0] stat_ff, nxt_stat;      // sticky flag, read clears
    logic [0:0] mask_ff, nxt_mask;      // interrupt mask
    logic irq_ff, nxt_irq;              // interrupt level
    logic [3:0] pos_rt_ff, nxt_pos_rt;  // positive route switches
    logic [2:0] neg_rt_ff, nxt_neg_rt;  // negative route switches
    logic neg_rsv_ff, nxt_neg_rsv;      // reserved negative code held
    // write channel holding
    logic aw_held_ff, nxt_aw_held;
    logic [7:0] aw_addr_ff, nxt_aw_addr;
    logic w_held_ff, nxt_w_held;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0] w_strb_ff, nxt_w_strb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic awready_ff, nxt_awready;  // write address slot free
    logic wready_ff, nxt_wready;    // write data slot free
    // read channel
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic arready_ff, nxt_arready;  // read slot free

    logic aw_take, w_take, ar_take, wr_commit;
    cmpx_pkg::cmpx_reg_e wr_reg, rd_reg;
    logic [0:0] evt_set;  // hardware events this cycle

    // ------------------------------------------------------------
    // edge detector
    // ------------------------------------------------------------
    cmpx_edge_if eif();

    assign eif.level = cmp_result_bit;
    assign eif.rise_en = ctrl_ff[cmpx_pkg::RISE_EN_BIT];  // R6
    assign eif.fall_en = ctrl_ff[cmpx_pkg::FALL_EN_BIT];  // R1 R2

    cmpx_edge_det cmpx_edge_det_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .eif(eif)
    );

    // ------------------------------------------------------------
    // handshake terms
    // ------------------------------------------------------------
    // one write at a time: address and data stop being taken until the answer leaves
    assign aw_take = s_axi_awvalid && !aw_held_ff && !bvalid_ff;
    assign w_take = s_axi_wvalid && !w_held_ff && !bvalid_ff;
    assign wr_commit = aw_held_ff && w_held_ff && !bvalid_ff;
    assign ar_take = s_axi_arvalid && !rvalid_ff;
    assign wr_reg = cmpx_pkg::cmpx_decode(aw_addr_ff);
    assign rd_reg = cmpx_pkg::cmpx_decode(8'(s_axi_araddr));
    assign evt_set[cmpx_pkg::FLAG_BIT] = eif.rise_evt || eif.fall_evt;  // R1 R6

    // ------------------------------------------------------------
    // write path: capture address and data in either order, then commit
    // ------------------------------------------------------------
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held = w_held_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (aw_take) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = 8'(s_axi_awaddr);
        end
        if (w_take) begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        if (wr_commit) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            // status and result are read-only; writes to them are accepted and dropped
            nxt_bresp = (wr_reg == cmpx_pkg::CMPX_R_NONE) ? cmpx_pkg::RESP_SLVERR
                                                          : cmpx_pkg::RESP_OKAY;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        // readies are registered so the bus outputs come straight from flops
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready = !nxt_w_held && !nxt_bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= cmpx_pkg::RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end else begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff <= nxt_w_held;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
        end
    end

    // ------------------------------------------------------------
    // registers, routing and interrupt
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        // only byte lane 0 carries register bits
        if (wr_commit && w_strb_ff[0]) begin
            if (wr_reg == cmpx_pkg::CMPX_R_CTRL) begin
                // R4: select fields land at their bit positions; bit 3 stays zero
                nxt_ctrl = w_data_ff[7:0] & cmpx_pkg::CTRL_WMASK;  // R4
            end
            if (wr_reg == cmpx_pkg::CMPX_R_MASK) begin
                nxt_mask = w_data_ff[cmpx_pkg::STAT_W-1:0];
            end
        end
        // a read of status clears it, but an event in that same cycle survives
        nxt_stat = stat_ff;
        if (ar_take && rd_reg == cmpx_pkg::CMPX_R_STAT) begin
            nxt_stat = '0;
        end
        nxt_stat = nxt_stat | evt_set;  // R1 R6
        // routes follow the stored code one cycle later
        nxt_pos_rt = cmpx_pkg::cmpx_pos_route(
            ctrl_ff[cmpx_pkg::POS_SEL_LSB +: cmpx_pkg::POS_SEL_W]);  // R3
        nxt_neg_rt = cmpx_pkg::cmpx_neg_route(
            ctrl_ff[cmpx_pkg::NEG_SEL_LSB +: cmpx_pkg::NEG_SEL_W]);  // R5
        nxt_neg_rsv = (nxt_neg_rt == 3'h0);  // R5
        // interrupt tracks the next flag so it rises with the flag itself
        nxt_irq = |(nxt_stat & nxt_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= cmpx_pkg::CTRL_RST;
            stat_ff <= cmpx_pkg::STAT_RST;
            mask_ff <= cmpx_pkg::STAT_RST;
            irq_ff <= 1'b0;
            pos_rt_ff <= 4'h1;
            neg_rt_ff <= 3'h1;
            neg_rsv_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
            pos_rt_ff <= nxt_pos_rt;
            neg_rt_ff <= nxt_neg_rt;
            neg_rsv_ff <= nxt_neg_rsv;
        end
    end

    // ------------------------------------------------------------
    // read path: data captured at the address handshake
    // ------------------------------------------------------------
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (ar_take) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = cmpx_pkg::RESP_OKAY;
            unique case (rd_reg)
                cmpx_pkg::CMPX_R_CTRL: nxt_rdata = {24'h000000, ctrl_ff};
                cmpx_pkg::CMPX_R_STAT: nxt_rdata = {31'h00000000, stat_ff};
                cmpx_pkg::CMPX_R_MASK: nxt_rdata = {31'h00000000, mask_ff};
                cmpx_pkg::CMPX_R_RSLT: nxt_rdata = {31'h00000000, cmp_result_bit};
                cmpx_pkg::CMPX_R_NONE: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = cmpx_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= cmpx_pkg::RESP_OKAY;
            arready_ff <= 1'b1;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            arready_ff <= nxt_arready;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign pos_input_sel = ctrl_ff[cmpx_pkg::POS_SEL_LSB +: cmpx_pkg::POS_SEL_W];  // R3
    assign neg_input_sel = ctrl_ff[cmpx_pkg::NEG_SEL_LSB +: cmpx_pkg::NEG_SEL_W];  // R4
    assign pos_route = pos_rt_ff;
    assign neg_route = neg_rt_ff;
    assign neg_sel_reserved = neg_rsv_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_fall_sets_flag: assert property ( // R1
        ($fell(cmp_result_bit) && cmpx_edge_det_inst.primed_ff && ctrl_ff[cmpx_pkg::FALL_EN_BIT])
        |=> stat_ff[cmpx_pkg::FLAG_BIT])
        else $error("falling edge with enable did not set flag");

    chk_fall_ignored: assert property ( // R2
        (!stat_ff[0] && $fell(cmp_result_bit) && !ctrl_ff[cmpx_pkg::FALL_EN_BIT])
        |=> !stat_ff[0])
        else $error("falling edge set flag while disabled");

    chk_pos_route_map: assert property ( // R3
        1'b1 |=> pos_route == (4'h1 << $past(ctrl_ff[5:4])) && pos_input_sel == ctrl_ff[5:4])
        else $error("positive route does not match select");

    chk_neg_field_write: assert property ( // R4
        (wr_commit && w_strb_ff[0] && wr_reg == cmpx_pkg::CMPX_R_CTRL)
        |=> neg_input_sel == $past(w_data_ff[2:0]) && !ctrl_ff[3])
        else $error("negative select not written into bits 2-0");

    chk_neg_fixed_ref: assert property ( // R5
        (neg_input_sel == 3'h4) |=> neg_route == 3'h4 && !neg_sel_reserved)
        else $error("code 100 did not route fixed reference");

    chk_neg_reserved: assert property ( // R5
        (neg_input_sel[1] || neg_input_sel == 3'h5 || neg_input_sel == 3'h7)
        |=> neg_route == 3'h0 && neg_sel_reserved)
        else $error("reserved negative code closed a switch");

    chk_rise_gate: assert property ( // R6
        (!stat_ff[0] && $rose(cmp_result_bit) && $past(cmpx_edge_det_inst.primed_ff))
        |=> stat_ff[0] == $past(ctrl_ff[cmpx_pkg::RISE_EN_BIT]))
        else $error("rising edge flag does not follow enable");

    chk_irq_level: assert property (
        ##1 irq == |(stat_ff & mask_ff))
        else $error("interrupt does not follow masked status");

    chk_write_answer: assert property (
        wr_commit |=> (s_axi_bvalid until_with s_axi_bready))
        else $error("write answer missing or dropped early");

endmodule
`default_nettype wire

// [hw/cmpx_edge_det.sv]
// edge detector on the comparator result bit with per-direction enables
`timescale 1ns/100ps
`default_nettype none
module cmpx_edge_det (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // detector side of the carrier
    cmpx_edge_if.det eif
);

    logic prev_ff;    // result bit one cycle ago
    logic primed_ff;  // a first sample has been taken
    logic nxt_prev;
    logic nxt_primed;

    // ------------------------------------------------------------
    // history: the first sample after reset only primes, so a result
    // already high at reset does not look like a rising edge
    // ------------------------------------------------------------
    always_comb begin
        nxt_prev = eif.level;
        nxt_primed = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_ff <= 1'b0;
            primed_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            primed_ff <= nxt_primed;
        end
    end

    // edges are gated by their enables here
    assign eif.rise_evt = primed_ff && eif.level && !prev_ff && eif.rise_en;  // R6
    assign eif.fall_evt = primed_ff && !eif.level && prev_ff && eif.fall_en;  // R1 R2

endmodule
`default_nettype wire

// [hw/cmpx_edge_if.sv]
// carrier between the control top and the result edge detector
`timescale 1ns/100ps
`default_nettype none
interface cmpx_edge_if;
    logic level;     // comparator result bit
    logic rise_en;   // rising edge enable
    logic fall_en;   // falling edge enable
    logic rise_evt;  // qualified rising edge, one cycle
    logic fall_evt;  // qualified falling edge, one cycle
    modport det (input level, input rise_en, input fall_en, output rise_evt, output fall_evt);
    modport ctl (output level, output rise_en, output fall_en, input rise_evt, input fall_evt);
endinterface
`default_nettype wire

// [hw/cmpx_pkg.sv]
// constants, register map and decode helpers for the comparator input/edge control block
package cmpx_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the control bus
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL_OFS = 8'h00;  // comparator_input_select_ctrl
    localparam logic [7:0] REG_STAT_OFS = 8'h04;  // sticky event status, read clears
    localparam logic [7:0] REG_MASK_OFS = 8'h08;  // interrupt mask, same layout as status
    localparam logic [7:0] REG_RSLT_OFS = 8'h0C;  // live comparator result bit

    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    localparam int CTRL_W = 8;
    localparam int RISE_EN_BIT = 7;
    localparam int FALL_EN_BIT = 6;
    localparam int POS_SEL_LSB = 4;
    localparam int POS_SEL_W = 2;
    localparam int NEG_SEL_LSB = 0;
    localparam int NEG_SEL_W = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hF7;  // bit 3 unimplemented, reads zero

    // ------------------------------------------------------------
    // status / mask layout
    // ------------------------------------------------------------
    localparam int STAT_W = 1;
    localparam int FLAG_BIT = 0;
    localparam logic [0:0] STAT_RST = 1'h0;

    // ------------------------------------------------------------
    // input routing codes and one-hot route vectors
    // ------------------------------------------------------------
    localparam int POS_ROUTES = 4;  // pin, dac, fixed ref, ground
    localparam int NEG_ROUTES = 3;  // pin zero, pin one, fixed ref
    localparam logic [2:0] NEG_PIN_ZERO = 3'h0;
    localparam logic [2:0] NEG_PIN_ONE = 3'h1;
    localparam logic [2:0] NEG_FIXED_REF = 3'h4;
    localparam int NEG_RT_PIN0 = 0;
    localparam int NEG_RT_PIN1 = 1;
    localparam int NEG_RT_FVR = 2;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CMPX_R_CTRL,
        CMPX_R_STAT,
        CMPX_R_MASK,
        CMPX_R_RSLT,
        CMPX_R_NONE
    } cmpx_reg_e;

    // exact decode of a byte address, shared by read and write paths
    function automatic cmpx_reg_e cmpx_decode(input logic [7:0] addr);
        cmpx_reg_e r;
        r = CMPX_R_NONE;
        if (addr == REG_CTRL_OFS) r = CMPX_R_CTRL;
        if (addr == REG_STAT_OFS) r = CMPX_R_STAT;
        if (addr == REG_MASK_OFS) r = CMPX_R_MASK;
        if (addr == REG_RSLT_OFS) r = CMPX_R_RSLT;
        return r;
    endfunction

    // one-hot positive routing: code n closes switch n
    function automatic logic [3:0] cmpx_pos_route(input logic [1:0] code);
        return 4'h1 << code;
    endfunction

    // one-hot negative routing; reserved codes close no switch
    function automatic logic [2:0] cmpx_neg_route(input logic [2:0] code);
        logic [2:0] r;
        r = 3'h0;
        if (code == NEG_PIN_ZERO) r[NEG_RT_PIN0] = 1'b1;
        if (code == NEG_PIN_ONE) r[NEG_RT_PIN1] = 1'b1;
        if (code == NEG_FIXED_REF) r[NEG_RT_FVR] = 1'b1;
        return r;
    endfunction

endpackage

// [tb/test_comparator_input_edge_control.sv]
// self-checking bench for the comparator input select and edge interrupt control block
`timescale 1ns/100ps
`default_nettype none
module test_comparator_input_edge_control;

    // ------------------------------------------------------------
    // stimulus and observation signals
    // ------------------------------------------------------------
    logic aclk;  // 100 mhz system clock
    logic aresetn;  // synchronous reset, active low
    logic [7:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [7:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic cmp_result_bit;  // comparator result driven by the bench
    logic [1:0] pos_input_sel;
    logic [2:0] neg_input_sel;
    logic [3:0] pos_route;
    logic [2:0] neg_route;
    logic neg_sel_reserved;
    logic irq;
    int bad_count;  // mismatches seen
    int n_compared;  // comparisons made
    logic [31:0] lfsr_ff;  // random source, fixed start
    logic [31:0] rd;  // last read data
    logic [1:0] rs;  // last response code

    // ------------------------------------------------------------
    // device under test
    // ------------------------------------------------------------
    cmpx_ctrl_top #(.ADDR_W(8)) cmpx_ctrl_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .cmp_result_bit(cmp_result_bit), .pos_input_sel(pos_input_sel),
        .neg_input_sel(neg_input_sel), .pos_route(pos_route), .neg_route(neg_route),
        .neg_sel_reserved(neg_sel_reserved), .irq(irq)
    );

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // the whole run needs a few hundred cycles; 20000 leaves a wide margin
    initial begin
        #200000;
        bad_count = bad_count + 1;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // expectation helpers, written from the register layout
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    // one-hot positive switch: pin, dac, fixed ref, ground
    function automatic logic [3:0] exp_pos(input logic [1:0] c);
        return (c == 2'h0) ? 4'h1 : (c == 2'h1) ? 4'h2 : (c == 2'h2) ? 4'h4 : 4'h8;
    endfunction

    // negative switch; reserved codes close nothing
    function automatic logic [2:0] exp_neg(input logic [2:0] c);
        return (c == 3'h0) ? 3'h1 : (c == 3'h1) ? 3'h2 : (c == 3'h4) ? 3'h4 : 3'h0;
    endfunction

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: response %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus master tasks; every change just after a rising edge
    // ------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_done;
        logic w_done;
        logic b_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // address and data may be taken in either order, the answer follows both
        while (!b_done && n < 200) begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                b_done = 1'b1;
            end
        end
        if (!b_done) bad_count = bad_count + 1;
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        logic r_done;
        n = 0;
        r_done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_done && n < 200) begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                r_done = 1'b1;
            end
        end
        if (!r_done) bad_count = bad_count + 1;
    endtask

    // let a few edges pass, then look at settled outputs
    task automatic settle(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask

    // toggle the result bit and check flag and irq against the enable
    task automatic edge_case(input logic lvl, input logic exp_flag, input logic exp_irq);
        @(posedge aclk);
        cmp_result_bit <= lvl;
        settle(3);
        cmp_data({31'h0, irq}, {31'h0, exp_irq});
        axi_read(cmpx_pkg::REG_STAT_OFS);
        cmp_data(rd, {31'h0, exp_flag});
        settle(1);
        cmp_data({31'h0, irq}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        cmp_result_bit = 1'b0;
        bad_count = 0;
        n_compared = 0;
        lfsr_ff = 32'hA56F8163;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        settle(1);
        // reset values of routes and registers
        cmp_data({28'h0, pos_route}, 32'h1);
        cmp_data({29'h0, neg_route}, 32'h1);
        cmp_data({31'h0, irq}, 32'h0);
        axi_read(cmpx_pkg::REG_CTRL_OFS);
        cmp_data(rd, 32'h0);
        axi_read(cmpx_pkg::REG_MASK_OFS);
        cmp_data(rd, 32'h0);
        // every positive and negative code, random upper bits around them
        for (int i = 0; i < 32; i++) begin
            lfsr_ff = lfsr_next(lfsr_ff);
            d = {lfsr_ff[31:8], lfsr_ff[7:6], i[4:3], lfsr_ff[3], i[2:0]};
            axi_write(cmpx_pkg::REG_CTRL_OFS, d);
            cmp_resp(rs, cmpx_pkg::RESP_OKAY);
            settle(1);
            cmp_data({30'h0, pos_input_sel}, {30'h0, d[5:4]});
            cmp_data({28'h0, pos_route}, {28'h0, exp_pos(d[5:4])});
            cmp_data({29'h0, neg_input_sel}, {29'h0, d[2:0]});
            cmp_data({29'h0, neg_route}, {29'h0, exp_neg(d[2:0])});
            cmp_data({31'h0, neg_sel_reserved}, {31'h0, exp_neg(d[2:0]) == 3'h0});
            axi_read(cmpx_pkg::REG_CTRL_OFS);
            cmp_data(rd, {24'h0, d[7:0] & 8'hF7});
        end
        // unmapped place: error answer, zero data
        axi_write(8'h10, 32'hFFFFFFFF);
        cmp_resp(rs, cmpx_pkg::RESP_SLVERR);
        axi_read(8'h10);
        cmp_resp(rs, cmpx_pkg::RESP_SLVERR);
        cmp_data(rd, 32'h0);
        // all four enable combinations, unmasked
        axi_write(cmpx_pkg::REG_MASK_OFS, 32'h1);
        axi_read(cmpx_pkg::REG_STAT_OFS);
        for (int m = 0; m < 4; m++) begin
            axi_write(cmpx_pkg::REG_CTRL_OFS, {24'h0, m[1], m[0], 6'h00});
            edge_case(1'b1, m[1], m[1]);
            axi_read(cmpx_pkg::REG_RSLT_OFS);
            cmp_data(rd, 32'h1);
            edge_case(1'b0, m[0], m[0]);
        end
        // masked: flag still set, irq quiet, a write does not clear it
        axi_write(cmpx_pkg::REG_MASK_OFS, 32'h0);
        axi_write(cmpx_pkg::REG_CTRL_OFS, 32'h000000C0);
        @(posedge aclk);
        cmp_result_bit <= 1'b1;
        settle(3);
        cmp_data({31'h0, irq}, 32'h0);
        axi_write(cmpx_pkg::REG_STAT_OFS, 32'h0);
        cmp_resp(rs, cmpx_pkg::RESP_OKAY);
        axi_read(cmpx_pkg::REG_STAT_OFS);
        cmp_data(rd, 32'h1);
        settle(2);
        tally_and_finish();
    end

endmodule
`default_nettype wire
